// file: include/rsac_pkg.sv
// Purpose: Shared constants and carrier types for the RTC serial access block.
// Assumes: Core clock of 125 MHz and a 32768 Hz oscillator pin.
// Notes:   Time registers hold plain binary counts.
package rsac_pkg;
    localparam logic [6:0] RSAC_DEV_ADDR      = 7'h32;
    localparam logic [3:0] RSAC_PTR_IDLE      = 4'hf;
    localparam logic [3:0] RSAC_FMT_RESTART   = 4'h0;
    localparam logic [3:0] RSAC_FMT_IMMEDIATE = 4'h4;
    localparam logic [7:0] RSAC_ABORT_DATA    = 8'hff;
    localparam int RSAC_PTR_HI = 7;
    localparam int RSAC_PTR_LO = 4;
    localparam int RSAC_FMT_HI = 3;
    localparam int RSAC_FMT_LO = 0;
    localparam int RSAC_CLK_HZ       = 125_000_000;
    localparam int RSAC_TIMEOUT_MS   = 500;
    localparam int RSAC_TIMEOUT_CYC  = RSAC_TIMEOUT_MS * (RSAC_CLK_HZ / 1000);
    localparam int RSAC_WDOG_W       = 26;
    localparam int RSAC_OSC_PER_SEC  = 32768;
    localparam int RSAC_TRIM_EVERY   = 20;
    localparam int RSAC_DIV_W        = 17;
    localparam logic [3:0] RSAC_REG_SEC  = 4'h0;
    localparam logic [3:0] RSAC_REG_MIN  = 4'h1;
    localparam logic [3:0] RSAC_REG_HOUR = 4'h2;
    localparam logic [3:0] RSAC_REG_TRIM = 4'h7;
    localparam logic [7:0] RSAC_SEC_LAST  = 8'h3b;
    localparam logic [7:0] RSAC_MIN_LAST  = 8'h3b;
    localparam logic [7:0] RSAC_HOUR_LAST = 8'h17;
    localparam int RSAC_TRIM_FIELD_MSB = 6;
    localparam int RSAC_TRIM_FIELD_LSB = 0;
    localparam int RSAC_FIFO_DEPTH = 8;
    localparam int RSAC_FIFO_W     = 12;

    typedef enum logic [2:0] {
        RSAC_EV_START, RSAC_EV_STOP, RSAC_EV_ADDR, RSAC_EV_WR, RSAC_EV_RD
    } rsac_ev_e;

    typedef enum logic [2:0] {
        RSAC_L_IDLE, RSAC_L_ADDR, RSAC_L_WR, RSAC_L_WAIT, RSAC_L_ACK,
        RSAC_L_RDQ, RSAC_L_RD, RSAC_L_RACK
    } rsac_lst_e;

    typedef struct packed {
        rsac_ev_e   kind;
        logic [7:0] data;
    } rsac_req_s;

    typedef struct packed {
        logic       ack;
        logic       to_tx;
        logic [7:0] data;
    } rsac_rsp_s;

    typedef struct packed {
        logic [3:0] idx;
        logic [7:0] data;
    } rsac_wr_s;

    typedef struct packed {
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } rsac_time_s;
endpackage

// file: core/rsac_fifo.sv
// Purpose: Small synchronous FIFO with valid and ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes:   Output data comes straight from the storage flip-flops.
`timescale 1ns/1ps
module rsac_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wp;
        logic [AW:0]                 rp;
    } rsac_fifo_s;

    rsac_fifo_s r, n;

    always_comb begin
        n = r;
        in_ready  = (r.wp - r.rp) != (AW+1)'(DEPTH);
        out_valid = r.wp != r.rp;
        out_data  = r.mem[r.rp[AW-1:0]];
        if (in_valid && in_ready) begin
            n.mem[r.wp[AW-1:0]] = in_data;
            n.wp = r.wp + 1'b1;
        end
        if (out_valid && out_ready) begin
            n.rp = r.rp + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule

// file: core/rsac_sec_div.sv
// Purpose: Divides the oscillator pin down to one tick per second, with trimming.
// Assumes: Oscillator pin is asynchronous to clk and far slower.
// Notes:   Trimming stretches or shortens one second in every trim period.
`timescale 1ns/1ps
module rsac_sec_div
    import rsac_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // Oscillator and trim value
    input  wire logic       osc_i,
    input  wire logic [6:0] trim,
    // Seconds tick
    output logic            sec_tick
);
    typedef struct packed {
        logic                  o1;
        logic                  o2;
        logic                  o3;
        logic [RSAC_DIV_W-1:0] cnt;
        logic [4:0]            nsec;
        logic                  tick;
    } rsac_div_s;

    rsac_div_s r, n;

    always_comb begin
        logic signed [7:0]     d;
        logic [RSAC_DIV_W-1:0] len;
        d   = 8'sh00;
        len = RSAC_DIV_W'(RSAC_OSC_PER_SEC);
        n = r;
        n.o1 = osc_i;
        n.o2 = r.o1;
        n.o3 = r.o2;
        n.tick = 1'b0;
        // A zero middle field disables the correction whatever the end bits hold.
        if (trim[RSAC_TRIM_FIELD_MSB-1:RSAC_TRIM_FIELD_LSB+1] != 5'h00) begin
            if (trim[RSAC_TRIM_FIELD_MSB]) begin
                d = signed'({trim[RSAC_TRIM_FIELD_MSB], trim});
            end else begin
                d = signed'({1'b0, trim}) - 8'sh01;
            end
        end
        if (r.nsec == 5'(RSAC_TRIM_EVERY - 1)) begin
            len = RSAC_DIV_W'(RSAC_OSC_PER_SEC + int'(d));
        end
        if (r.o2 && !r.o3) begin
            if (r.cnt >= len - 1'b1) begin
                n.cnt  = '0;
                n.tick = 1'b1;
                n.nsec = (r.nsec == 5'(RSAC_TRIM_EVERY - 1)) ? 5'h00 : r.nsec + 5'h01;
            end else begin
                n.cnt = r.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign sec_tick = r.tick;
endmodule

// file: core/rsac_rtc_access.sv
// Purpose: Two-wire slave access control for a real-time clock register file.
// Assumes: link_clk samples the bus far faster than the bus bit rate.
// Notes:   Bit level runs on link_clk; pointer, hold and timeout run on clk.
`timescale 1ns/1ps

// What this block does
// - Pointer write with format zero, repeated start, then read from that pointer.
// - Every stop condition loads the register pointer with F hex.
// - Format four switches device to transmit at once, from the pointer onward.
// - A direct read starts at the current pointer, F hex after a stop.
// - Time counters freeze from start to stop; pending carry applied after stop.
// - Transaction open past half a second is aborted like a stop.
// - A start before any stop is repeated and keeps the timeout running.
// - After an abort, writes get no acknowledge and reads return all ones.
// - Trimming alters the oscillator count of one second in every twenty.
// - Zero middle five trim bits means no correction.
// - Pointer increments after each data byte, wrapping from F hex to zero.
// - Device answers only to its seven-bit bus address, sent MSB first.
// - Byte after address and write bit carries pointer and format code.
module rsac_rtc_access
    import rsac_pkg::*;
#(
    parameter int TIMEOUT_CYC = RSAC_TIMEOUT_CYC
) (
    // Core clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Bus sampling clock
    input  wire logic link_clk,
    // Two-wire bus pins
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe,
    // Oscillator pin
    input  wire logic osc_i,
    // Status for the rest of the chip
    output rsac_time_s time_o,
    output logic      counters_held,
    output logic      txn_aborted
);
    typedef struct packed {
        logic      scl1;
        logic      scl2;
        logic      scl3;
        logic      sda1;
        logic      sda2;
        logic      sda3;
        logic      rt1;
        logic      rt2;
        rsac_lst_e st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic      rw;
        logic      nrd;
        logic      oe;
        logic      req_tog;
        rsac_req_s req;
        rsac_req_s bev;
        logic      pend_start;
        logic      pend_stop;
        logic      byte_pend;
    } rsac_link_s;

    typedef struct packed {
        logic       rq1;
        logic       rq2;
        logic       rq3;
        logic       rsp_tog;
        rsac_rsp_s  rsp;
        logic [3:0] ptr;
        logic       in_txn;
        logic       aborted;
        logic       hold;
        logic       carry_pend;
        logic       expect_ptr;
        logic [RSAC_WDOG_W-1:0] wdog;
        logic [15:0][7:0] regs;
    } rsac_core_s;

    rsac_link_s lr, ln;
    rsac_core_s r, n;

    logic     sec_tick;
    logic     fin_valid;
    logic     fin_ready;
    rsac_wr_s fin_data;
    logic     fout_valid;
    logic     fout_ready;
    rsac_wr_s fout_data;

    rsac_sec_div u_div (
        .clk      (clk),
        .arst_n   (arst_n),
        .osc_i    (osc_i),
        .trim     (r.regs[RSAC_REG_TRIM][RSAC_TRIM_FIELD_MSB:RSAC_TRIM_FIELD_LSB]),
        .sec_tick (sec_tick)
    );

    // Writes queue here so a busy time update never loses a bus byte.
    rsac_fifo #(
        .WIDTH (RSAC_FIFO_W),
        .DEPTH (RSAC_FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .arst_n    (arst_n),
        .in_valid  (fin_valid),
        .in_ready  (fin_ready),
        .in_data   (fin_data),
        .out_valid (fout_valid),
        .out_ready (fout_ready),
        .out_data  (fout_data)
    );

    // Link side: bit level of the bus, on link_clk.
    always_comb begin
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
        logic busy;
        logic done;
        scl_rise = lr.scl2 & ~lr.scl3;
        scl_fall = ~lr.scl2 & lr.scl3;
        start    = lr.scl2 & lr.scl3 & ~lr.sda2 & lr.sda3;
        stop     = lr.scl2 & lr.scl3 & lr.sda2 & ~lr.sda3;
        busy     = lr.req_tog != lr.rt2;
        done     = !busy && !lr.byte_pend;
        ln = lr;
        ln.scl1 = scl_i;
        ln.scl2 = lr.scl1;
        ln.scl3 = lr.scl2;
        ln.sda1 = sda_i;
        ln.sda2 = lr.sda1;
        ln.sda3 = lr.sda2;
        ln.rt1  = r.rsp_tog;
        ln.rt2  = lr.rt1;
        unique case (lr.st)
            RSAC_L_IDLE: begin
            end
            RSAC_L_ADDR, RSAC_L_WR: begin
                if (scl_rise) begin
                    ln.sh  = {lr.sh[6:0], lr.sda2};
                    ln.cnt = lr.cnt + 4'h1;
                end else if (scl_fall && lr.cnt == 4'h8) begin
                    if (lr.st == RSAC_L_WR) begin
                        ln.bev       = '{kind: RSAC_EV_WR, data: lr.sh};
                        ln.byte_pend = 1'b1;
                        ln.st        = RSAC_L_WAIT;
                    end else if (lr.sh[7:1] == RSAC_DEV_ADDR) begin
                        ln.rw        = lr.sh[0];
                        ln.bev       = '{kind: RSAC_EV_ADDR, data: lr.sh};
                        ln.byte_pend = 1'b1;
                        ln.st        = RSAC_L_WAIT;
                    end else begin
                        ln.st = RSAC_L_IDLE;
                    end
                end
            end
            RSAC_L_WAIT: begin
                if (done) begin
                    if (r.rsp.ack) begin
                        ln.oe  = 1'b1;
                        ln.nrd = (lr.bev.kind == RSAC_EV_ADDR && lr.rw) ||
                                 (lr.bev.kind == RSAC_EV_WR && r.rsp.to_tx);
                        ln.st  = RSAC_L_ACK;
                    end else begin
                        ln.st = RSAC_L_IDLE;
                    end
                end
            end
            RSAC_L_ACK: begin
                if (scl_fall) begin
                    ln.oe  = 1'b0;
                    ln.cnt = 4'h0;
                    if (lr.nrd) begin
                        ln.bev       = '{kind: RSAC_EV_RD, data: 8'h00};
                        ln.byte_pend = 1'b1;
                        ln.st        = RSAC_L_RDQ;
                    end else begin
                        ln.st = RSAC_L_WR;
                    end
                end
            end
            RSAC_L_RDQ: begin
                if (done) begin
                    ln.sh  = r.rsp.data;
                    ln.oe  = ~r.rsp.data[7];
                    ln.cnt = 4'h1;
                    ln.st  = RSAC_L_RD;
                end
            end
            RSAC_L_RD: begin
                if (scl_fall) begin
                    if (lr.cnt == 4'h8) begin
                        ln.oe = 1'b0;
                        ln.st = RSAC_L_RACK;
                    end else begin
                        ln.oe  = ~lr.sh[6];
                        ln.sh  = {lr.sh[6:0], 1'b0};
                        ln.cnt = lr.cnt + 4'h1;
                    end
                end
            end
            RSAC_L_RACK: begin
                if (scl_rise) begin
                    ln.nrd = ~lr.sda2;
                end else if (scl_fall) begin
                    if (lr.nrd) begin
                        ln.bev       = '{kind: RSAC_EV_RD, data: 8'h00};
                        ln.byte_pend = 1'b1;
                        ln.st        = RSAC_L_RDQ;
                    end else begin
                        ln.st = RSAC_L_IDLE;
                    end
                end
            end
        endcase
        if (start) begin
            ln.pend_start = 1'b1;
            ln.byte_pend  = 1'b0;
            ln.oe         = 1'b0;
            ln.cnt        = 4'h0;
            ln.st         = RSAC_L_ADDR;
        end
        if (stop) begin
            // A start that never reached the core is dropped; the stop still goes there.
            ln.pend_stop  = 1'b1;
            ln.pend_start = 1'b0;
            ln.byte_pend  = 1'b0;
            ln.oe         = 1'b0;
            ln.st         = RSAC_L_IDLE;
        end
        if (!busy) begin
            if (ln.pend_stop) begin
                ln.req       = '{kind: RSAC_EV_STOP, data: 8'h00};
                ln.pend_stop = 1'b0;
                ln.req_tog   = ~lr.req_tog;
            end else if (ln.pend_start) begin
                ln.req        = '{kind: RSAC_EV_START, data: 8'h00};
                ln.pend_start = 1'b0;
                ln.req_tog    = ~lr.req_tog;
            end else if (ln.byte_pend) begin
                ln.req       = ln.bev;
                ln.byte_pend = 1'b0;
                ln.req_tog   = ~lr.req_tog;
            end
        end
    end

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            lr      <= '0;
            lr.scl1 <= 1'b1;
            lr.scl2 <= 1'b1;
            lr.scl3 <= 1'b1;
            lr.sda1 <= 1'b1;
            lr.sda2 <= 1'b1;
            lr.sda3 <= 1'b1;
        end else begin
            lr <= ln;
        end
    end

    // Core side: pointer, register file, hold and timeout, on clk.
    always_comb begin
        logic ev;
        logic adv;
        ev  = r.rq2 ^ r.rq3;
        adv = !r.hold && (r.carry_pend || sec_tick);
        n = r;
        n.rq1 = lr.req_tog;
        n.rq2 = r.rq1;
        n.rq3 = r.rq2;
        // A tick that lands inside a transaction waits until the hold drops.
        n.carry_pend = r.hold ? (r.carry_pend || sec_tick) : (r.carry_pend && sec_tick);
        fout_ready = !adv;
        fin_valid  = ev && lr.req.kind == RSAC_EV_WR && !r.aborted && !r.expect_ptr;
        fin_data   = '{idx: r.ptr, data: lr.req.data};
        if (fout_valid && !adv) begin
            n.regs[fout_data.idx] = fout_data.data;
        end
        if (adv) begin
            if (r.regs[RSAC_REG_SEC] != RSAC_SEC_LAST) begin
                n.regs[RSAC_REG_SEC] = r.regs[RSAC_REG_SEC] + 8'h01;
            end else begin
                n.regs[RSAC_REG_SEC] = 8'h00;
                if (r.regs[RSAC_REG_MIN] != RSAC_MIN_LAST) begin
                    n.regs[RSAC_REG_MIN] = r.regs[RSAC_REG_MIN] + 8'h01;
                end else begin
                    n.regs[RSAC_REG_MIN] = 8'h00;
                    n.regs[RSAC_REG_HOUR] = (r.regs[RSAC_REG_HOUR] == RSAC_HOUR_LAST) ?
                                            8'h00 : r.regs[RSAC_REG_HOUR] + 8'h01;
                end
            end
        end
        if (r.in_txn && !r.aborted) begin
            n.wdog = r.wdog + 1'b1;
            if (r.wdog == RSAC_WDOG_W'(TIMEOUT_CYC - 1)) begin
                n.aborted = 1'b1;
                n.hold    = 1'b0;
                n.ptr     = RSAC_PTR_IDLE;
            end
        end
        if (ev) begin
            n.rsp_tog = ~r.rsp_tog;
            n.rsp     = '{ack: 1'b1, to_tx: 1'b0, data: 8'h00};
            unique case (lr.req.kind)
                RSAC_EV_START: begin
                    if (!r.in_txn) begin
                        n.in_txn  = 1'b1;
                        n.wdog    = '0;
                        n.aborted = 1'b0;
                        n.hold    = 1'b1;
                    end
                    n.expect_ptr = 1'b0;
                end
                RSAC_EV_STOP: begin
                    n.in_txn     = 1'b0;
                    n.aborted    = 1'b0;
                    n.hold       = 1'b0;
                    n.expect_ptr = 1'b0;
                    n.ptr        = RSAC_PTR_IDLE;
                end
                RSAC_EV_ADDR: begin
                    // Reads stay acknowledged after an abort so the ones can be seen.
                    n.rsp.ack    = !n.aborted || lr.req.data[0];
                    n.expect_ptr = !lr.req.data[0];
                end
                RSAC_EV_WR: begin
                    if (n.aborted) begin
                        n.rsp.ack = 1'b0;
                    end else if (r.expect_ptr) begin
                        n.ptr        = lr.req.data[RSAC_PTR_HI:RSAC_PTR_LO];
                        n.rsp.to_tx  = lr.req.data[RSAC_FMT_HI:RSAC_FMT_LO]
                                       == RSAC_FMT_IMMEDIATE;
                        n.expect_ptr = 1'b0;
                    end else if (fin_ready) begin
                        n.ptr = r.ptr + 4'h1;
                    end else begin
                        n.rsp.ack = 1'b0;
                    end
                end
                RSAC_EV_RD: begin
                    if (n.aborted) begin
                        n.rsp.data = RSAC_ABORT_DATA;
                    end else begin
                        n.rsp.data = r.regs[r.ptr];
                        n.ptr      = r.ptr + 4'h1;
                    end
                end
                default: begin
                    n.rsp.ack = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r     <= '0;
            r.ptr <= RSAC_PTR_IDLE;
        end else begin
            r <= n;
        end
    end

    assign sda_o         = 1'b0;
    assign sda_oe        = lr.oe;
    assign time_o        = '{hour: r.regs[RSAC_REG_HOUR], min: r.regs[RSAC_REG_MIN],
                             sec: r.regs[RSAC_REG_SEC]};
    assign counters_held = r.hold;
    assign txn_aborted   = r.aborted;
endmodule

// file: test/rsac_chk_assertions.sv
// Purpose: Port-level checks of frame hold, abort and data line timing.
// Assumes: Bus pins seen at the wired level.
// Notes:   The hold length bounds the abort timer from both sides.
`timescale 1ns/1ps
module rsac_chk
    import rsac_pkg::*;
#(
    parameter int TIMEOUT_CYC = RSAC_TIMEOUT_CYC
) (
    // Clocks and reset
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic       link_clk,
    // Bus pins
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       sda_oe,
    // Status
    input wire rsac_time_s time_o,
    input wire logic       counters_held,
    input wire logic       txn_aborted
);
    int hold_cnt_r;
    int hold_cnt_nxt;
    always_comb hold_cnt_nxt = counters_held ? hold_cnt_r + 1 : 0;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_cnt_r <= 0;
        end else begin
            hold_cnt_r <= hold_cnt_nxt;
        end
    end
    sda_edge_a:
        assert property (@(posedge link_clk) disable iff (!arst_n)
        $changed(sda_oe) |-> !scl_i) else $error("Data line moved with clock high.");
    stop_release_a:
        assert property (@(posedge clk) disable iff (!arst_n)
        scl_i && $rose(sda_i) |-> ##[1:80] !counters_held) else $error("Hold kept past stop.");
    start_hold_a:
        assert property (@(posedge clk) disable iff (!arst_n) scl_i && $fell(sda_i)
        && !txn_aborted |-> ##[1:80] counters_held) else $error("No hold after start.");
    time_frozen_a:
        assert property (@(posedge clk) disable iff (!arst_n) counters_held
        && $past(counters_held) |-> $stable(time_o)) else $error("Time moved while held.");
    abort_release_a:
        assert property (@(posedge clk) disable iff (!arst_n)
        $rose(txn_aborted) |-> !counters_held) else $error("Abort kept the hold.");
    abort_late_a:
        assert property (@(posedge clk) disable iff (!arst_n) $rose(txn_aborted)
        |-> $past(hold_cnt_r) >= TIMEOUT_CYC - 16) else $error("Abort came too early.");
    hold_bound_a:
        assert property (@(posedge clk) disable iff (!arst_n)
        hold_cnt_r <= 2 * TIMEOUT_CYC) else $error("Hold outlived the abort limit.");
    stop_clear_a:
        assert property (@(posedge clk) disable iff (!arst_n)
        scl_i && $rose(sda_i) |-> ##[1:80] !txn_aborted) else $error("Abort kept past stop.");
    cover property (@(posedge clk) disable iff (!arst_n) $rose(txn_aborted));
    cover property (@(posedge clk) disable iff (!arst_n) $fell(counters_held));
    cover property (@(posedge link_clk) disable iff (!arst_n) $rose(sda_oe));
endmodule
bind rsac_rtc_access rsac_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk_u (.clk(clk), .arst_n(arst_n),
    .link_clk(link_clk), .scl_i(scl_i), .sda_i(sda_i), .sda_oe(sda_oe), .time_o(time_o),
    .counters_held(counters_held), .txn_aborted(txn_aborted));

// file: test/rsac_mst.sv
// Purpose: Behavioural two-wire bus master facing the device.
// Assumes: The bench resolves the wired data level with a pull-up.
// Notes:   Delays are multiples of 8 ns so bus events land on clk falling edges.
`timescale 1ns/1ps
module rsac_mst (
    // Bus pins
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda_bus
);
    localparam time T = 504;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // Waiting before the clock rises lets a late acknowledge clear first.
    task automatic start();
        sda_pull = 1'b0;
        #(3 * T) scl = 1'b1;
        #(2 * T) sda_pull = 1'b1;
        #(2 * T) scl = 1'b0;
        #T;
    endtask
    task automatic stop();
        sda_pull = 1'b1;
        #(3 * T) scl = 1'b1;
        #(2 * T) sda_pull = 1'b0;
        #(2 * T);
    endtask
    task automatic xbit(input logic v, output logic s);
        sda_pull = !v;
        #(3 * T) scl = 1'b1;
        #T s = sda_bus;
        #T scl = 1'b0;
        #T;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) xbit(b[i], s);
        xbit(1'b1, s);
        ack = !s;
    endtask
    task automatic rbyte(output logic [7:0] b, input logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) xbit(1'b1, b[i]);
        xbit(!ack, s);
    endtask
endmodule

// file: test/rsac_rtc_access_tb.sv
// Purpose: Self-checking bench for the RTC serial access block.
// Assumes: Oscillator pin idle, so the time registers stay at zero.
// Notes:   A short abort limit keeps the run brief.
`timescale 1ns/1ps
module rsac_rtc_access_tb
    import rsac_pkg::*;
;
    localparam int TO_CYC = 20000;
    localparam logic [7:0] AW = {RSAC_DEV_ADDR, 1'b0};
    localparam logic [7:0] AR = {RSAC_DEV_ADDR, 1'b1};
    logic       clk = 1'b0;
    logic       link_clk = 1'b0;
    logic       arst_n = 1'b0;
    logic       scl;
    logic       sda_pull;
    logic       sda_o;
    logic       sda_oe;
    logic       held;
    logic       aborted;
    rsac_time_s time_o;
    int         err_total = 0;
    int         cmp_count = 0;
    wire        sda_bus = !(sda_pull | sda_oe);
    always #4 clk = ~clk;
    always #62.5 link_clk = ~link_clk;
    rsac_rtc_access #(.TIMEOUT_CYC(TO_CYC)) dut_u (.clk(clk), .arst_n(arst_n),
        .link_clk(link_clk), .scl_i(scl), .sda_i(sda_bus), .sda_o(sda_o), .sda_oe(sda_oe),
        .osc_i(1'b0), .time_o(time_o), .counters_held(held), .txn_aborted(aborted));
    rsac_mst mst_u (.scl(scl), .sda_pull(sda_pull), .sda_bus(sda_bus));
    task automatic chk_bit(string nm, logic exp, logic got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %b seen %b", nm, exp, got);
        end
    endtask
    task automatic chk_byte(string nm, logic [7:0] exp, logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic sc_direct();
        logic a;
        logic [7:0] d;
        mst_u.start();
        mst_u.wbyte(AW, a);
        chk_bit("write address ack", 1'b1, a);
        chk_bit("hold in frame", 1'b1, held);
        chk_bit("sda level", 1'b0, sda_o);
        mst_u.wbyte({4'he, RSAC_FMT_RESTART}, a);
        chk_bit("pointer ack", 1'b1, a);
        mst_u.wbyte(8'h5a, a);
        mst_u.wbyte(8'ha5, a);
        chk_bit("data ack", 1'b1, a);
        mst_u.stop();
        repeat (100) @(negedge clk);
        chk_bit("hold after stop", 1'b0, held);
        chk_byte("seconds", 8'h00, time_o.sec);
        mst_u.start();
        mst_u.wbyte(AR, a);
        mst_u.rbyte(d, 1'b1);
        chk_byte("direct read reg f", 8'ha5, d);
        mst_u.rbyte(d, 1'b0);
        chk_byte("wrap to reg 0", 8'h00, d);
        mst_u.stop();
    endtask
    task automatic sc_restart();
        logic a;
        logic [7:0] d;
        mst_u.start();
        mst_u.wbyte(AW, a);
        mst_u.wbyte({4'he, RSAC_FMT_RESTART}, a);
        mst_u.start();
        chk_bit("hold over restart", 1'b1, held);
        mst_u.wbyte(AR, a);
        chk_bit("read address ack", 1'b1, a);
        mst_u.rbyte(d, 1'b1);
        chk_byte("restart read reg e", 8'h5a, d);
        mst_u.rbyte(d, 1'b0);
        chk_byte("restart read reg f", 8'ha5, d);
        mst_u.stop();
    endtask
    task automatic sc_immediate();
        logic a;
        logic [7:0] d;
        mst_u.start();
        mst_u.wbyte(AW, a);
        mst_u.wbyte({4'hf, RSAC_FMT_IMMEDIATE}, a);
        mst_u.rbyte(d, 1'b1);
        chk_byte("immediate read reg f", 8'ha5, d);
        mst_u.rbyte(d, 1'b0);
        chk_byte("immediate wrap reg 0", 8'h00, d);
        mst_u.stop();
    endtask
    task automatic sc_foreign();
        logic a;
        mst_u.start();
        mst_u.wbyte(AW ^ 8'h02, a);
        chk_bit("near address ack", 1'b0, a);
        mst_u.start();
        mst_u.wbyte({7'h26, 1'b0}, a);
        chk_bit("reversed address ack", 1'b0, a);
        mst_u.stop();
    endtask
    task automatic sc_abort();
        logic a;
        logic [7:0] d;
        int n;
        mst_u.start();
        mst_u.wbyte(AW, a);
        for (n = 0; n < 3 * TO_CYC && aborted !== 1'b1; n++) @(negedge clk);
        chk_bit("abort flag", 1'b1, aborted);
        if (n >= 3 * TO_CYC) conclude();
        chk_bit("hold released", 1'b0, held);
        mst_u.wbyte(8'h00, a);
        chk_bit("write after abort", 1'b0, a);
        mst_u.start();
        mst_u.wbyte(AR, a);
        mst_u.rbyte(d, 1'b0);
        chk_byte("read after abort", RSAC_ABORT_DATA, d);
        mst_u.stop();
    endtask
    initial begin
        repeat (3) @(negedge link_clk);
        @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(posedge link_clk);
        @(negedge clk);
        sc_direct();
        sc_restart();
        sc_immediate();
        sc_foreign();
        sc_abort();
        conclude();
    end
    initial begin
        repeat (110000) @(posedge clk);
        err_total++;
        conclude();
    end
endmodule
